// ---- hdl/ssc_pkg.sv ----
/*
  Shared constants and state types for the slave serial configuration link.
  Assumes a single 10 MHz system clock on both ends.
*/
package ssc_pkg;
  // ==========================================================================
  // Clock and frame layout
  // ==========================================================================
  localparam int CLK_NS         = 100;
  localparam int PREAMBLE_BITS  = 8;
  localparam int CFG_STORE_BITS = 64;
  localparam int FRAME_BITS     = PREAMBLE_BITS + CFG_STORE_BITS;
  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h7;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int RST_FILTER_NS   = 3000;
  localparam int RST_FILTER_CYC  = RST_FILTER_NS / CLK_NS;
  localparam int CLEAR_NS        = 2000;
  localparam int CLEAR_CYC       = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_RESP_NS    = 7000;
  localparam int INIT_RESP_CYC   = INIT_RESP_NS / CLK_NS;
  localparam int CONFIG_CLOCK_HALF_NS    = 400;
  localparam int CONFIG_CLOCK_HALF_CYC   = (CONFIG_CLOCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int RB_HALF_NS      = 600;
  localparam int RB_HALF_CYC     = (RB_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_LOW_NS     = 6000;
  localparam int PROG_LOW_CYC    = (PROG_LOW_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // State types
  // ==========================================================================
  typedef enum logic [1:0] {DEV_CLEAR, DEV_LOAD, DEV_DONE, DEV_READBACK} ssc_dev_state_t;
  typedef enum logic [2:0] {
    HST_IDLE, HST_ABORT, HST_PROG, HST_SEND_LO, HST_SEND_HI, HST_RB_ARM, HST_RB_LO, HST_RB_HI
  } ssc_host_state_t;
endpackage

// ---- hdl/ssc_link_if.sv ----
/*
  Link between the configuration source and the configured device.
  Assumes the done/program line is open drain with a pull-up.
*/
`timescale 1ns/1ns
interface ssc_link_if;
  logic       configClock;
  logic       serialDataIn;
  logic       serialDataOut;
  logic       initStatus;
  logic       cfgReset_b;
  logic [2:0] modeSelect;
  logic       readbackData_b;
  logic       devDoneOut;
  logic       devDoneOe;
  logic       hostDoneOut;
  logic       hostDoneOe;
  logic       doneProgramLine;

  // ==========================================================================
  // Open-drain resolution with pull-up
  // ==========================================================================
  assign doneProgramLine = !((devDoneOe && !devDoneOut) || (hostDoneOe && !hostDoneOut));

  modport device (
    input  configClock, serialDataIn, cfgReset_b, modeSelect, doneProgramLine,
    output serialDataOut, initStatus, readbackData_b, devDoneOut, devDoneOe
  );
  modport host (
    input  serialDataOut, initStatus, readbackData_b, doneProgramLine,
    output configClock, serialDataIn, cfgReset_b, modeSelect, hostDoneOut, hostDoneOe
  );
endinterface

// ---- hdl/ssc_sync.sv ----
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit may change at any time relative to clk.
*/
`timescale 1ns/1ns
module ssc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ==========================================================================
  // Two stages
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule // ssc_sync

// ---- hdl/ssc_device.sv ----
/*
  Configured device end: serial load, daisy-chain forwarding, reset filter,
  reprogram through the done/program line and readback.
  Assumes the far end supplies the configuration clock and keeps its rules.
*/
// Overview of operation
// - Far end supplies the configuration clock
// - Data bit captured on rising clock
// - Forward preamble and overflow bits downstream
// - Serial output changes on falling clock
// - Clock low never longer than 5 us
// - No bitstream before init status high
// - Readback clock at most 1 MHz
// - Trigger one clock after outputs active
// - Readback only after configuration completes
// - Abort by reset low 6 us
// - Reprogram by done line low 6 us
// - Init status drops within 7 us
// - Mode lines stable around reset release
// - Reset filtered by a 3 us counter of agreeing samples
// - Trigger rise starts readback of storage
// - Readback data driven active low
// - Idle configuration clock parked high
// - Done line fall restarts configuration
`timescale 1ns/1ns
module ssc_device (
  input  wire logic                               clk,
  input  wire logic                               rst_b,
  ssc_link_if.device                              link,
  output logic                                    cfgDone,
  output logic                                    readbackBusy,
  output logic [ssc_pkg::CFG_STORE_BITS-1:0]      cfgStore
);
  typedef struct packed {
    ssc_pkg::ssc_dev_state_t                state;
    logic                                   clkPrev;
    logic                                   trigPrev;
    logic                                   donePrev;
    logic                                   rstFilt_b;
    logic [5:0]                             rstCnt;
    logic [5:0]                             timer;
    logic [7:0]                             bitCnt;
    logic [6:0]                             rbCnt;
    logic [2:0]                             mode;
    logic [ssc_pkg::CFG_STORE_BITS-1:0]     store;
    logic                                   pendOut;
    logic                                   dout;
    logic                                   init;
    logic                                   doneOe;
    logic                                   rbData_b;
    logic                                   done;
    logic                                   rbBusy;
  } ssc_dev_reg_t;

  localparam logic [5:0] FILT_LAST  = 6'(ssc_pkg::RST_FILTER_CYC - 1);
  localparam logic [5:0] CLEAR_LAST = 6'(ssc_pkg::CLEAR_CYC - 1);
  localparam logic [7:0] PRE_BITS   = 8'(ssc_pkg::PREAMBLE_BITS);
  localparam logic [7:0] FRAME_LAST = 8'(ssc_pkg::FRAME_BITS - 1);
  localparam logic [6:0] RB_BITS    = 7'(ssc_pkg::CFG_STORE_BITS);

  ssc_dev_reg_t q;
  ssc_dev_reg_t d;
  logic [6:0]   pinS;
  logic         clkS;
  logic         dinS;
  logic         rstS_b;
  logic [2:0]   modeS;
  logic         doneS;
  logic         clkRise;
  logic         clkFall;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  ssc_sync #(.W(7), .RST_VAL(7'h7F)) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .asyncIn  ({link.configClock, link.serialDataIn, link.cfgReset_b, link.modeSelect, link.doneProgramLine}),
    .syncOut  (pinS)
  );

  assign clkS    = pinS[6];
  assign dinS    = pinS[5];
  assign rstS_b  = pinS[4];
  assign modeS   = pinS[3:1];
  assign doneS   = pinS[0];
  assign clkRise = clkS && !q.clkPrev;
  assign clkFall = !clkS && q.clkPrev;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d          = q;
    d.clkPrev  = clkS;
    d.trigPrev = modeS[0];
    d.donePrev = doneS;

    // Reset only takes effect after a run of agreeing samples
    if (rstS_b == q.rstFilt_b) begin
      d.rstCnt = 6'h00;
    end else if (q.rstCnt == FILT_LAST) begin
      d.rstFilt_b = rstS_b;
      d.rstCnt    = 6'h00;
    end else begin
      d.rstCnt = q.rstCnt + 6'h01;
    end

    // Downstream bit moves half a clock after capture
    if (clkFall) begin
      d.dout = q.pendOut;
    end

    case (q.state)
      ssc_pkg::DEV_CLEAR: begin
        d.init   = 1'b0;
        d.doneOe = 1'b1;
        d.done   = 1'b0;
        d.rbBusy = 1'b0;
        d.dout   = 1'b1;
        d.pendOut = 1'b1;
        if (q.timer != CLEAR_LAST) begin
          d.timer = q.timer + 6'h01;
        end else if (q.rstFilt_b) begin
          d.mode   = modeS;
          d.bitCnt = 8'h00;
          d.init   = 1'b1;
          d.state  = ssc_pkg::DEV_LOAD;
        end
      end
      ssc_pkg::DEV_LOAD: begin
        if (!q.rstFilt_b) begin
          d.timer = 6'h00;
          d.init  = 1'b0;
          d.state = ssc_pkg::DEV_CLEAR;
        end else if (clkRise && q.mode == ssc_pkg::MODE_SLAVE_SERIAL) begin
          d.bitCnt = q.bitCnt + 8'h01;
          if (q.bitCnt < PRE_BITS) begin
            d.pendOut = dinS;
          end else begin
            d.store   = {q.store[ssc_pkg::CFG_STORE_BITS-2:0], dinS};
            d.pendOut = 1'b1;
          end
          if (q.bitCnt == FRAME_LAST) begin
            d.doneOe = 1'b0;
            d.done   = 1'b1;
            d.state  = ssc_pkg::DEV_DONE;
          end
        end
      end
      ssc_pkg::DEV_DONE: begin
        if (!doneS && q.donePrev) begin
          d.init  = 1'b0;
          d.timer = 6'h00;
          d.state = ssc_pkg::DEV_CLEAR;
        end else if (modeS[0] && !q.trigPrev) begin
          d.rbCnt  = 7'h00;
          d.rbBusy = 1'b1;
          d.state  = ssc_pkg::DEV_READBACK;
        end else if (clkRise) begin
          d.pendOut = dinS;
        end
      end
      ssc_pkg::DEV_READBACK: begin
        if (!doneS && q.donePrev) begin
          d.init     = 1'b0;
          d.timer    = 6'h00;
          d.rbData_b = 1'b1;
          d.state    = ssc_pkg::DEV_CLEAR;
        end else if (clkRise) begin
          if (q.rbCnt == RB_BITS) begin
            d.rbData_b = 1'b1;
            d.rbBusy   = 1'b0;
            d.state    = ssc_pkg::DEV_DONE;
          end else begin
            d.rbData_b = !q.store[ssc_pkg::CFG_STORE_BITS-1];
            d.store    = {q.store[ssc_pkg::CFG_STORE_BITS-2:0], q.store[ssc_pkg::CFG_STORE_BITS-1]};
            d.rbCnt    = q.rbCnt + 7'h01;
          end
        end
      end
      default: begin
        d.state = ssc_pkg::DEV_CLEAR;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q.state     <= ssc_pkg::DEV_CLEAR;
      q.clkPrev   <= 1'b1;
      q.trigPrev  <= 1'b1;
      q.donePrev  <= 1'b1;
      q.rstFilt_b <= 1'b1;
      q.rstCnt    <= 6'h00;
      q.timer     <= 6'h00;
      q.bitCnt    <= 8'h00;
      q.rbCnt     <= 7'h00;
      q.mode      <= 3'h0;
      q.store     <= '0;
      q.pendOut   <= 1'b1;
      q.dout      <= 1'b1;
      q.init      <= 1'b0;
      q.doneOe    <= 1'b1;
      q.rbData_b  <= 1'b1;
      q.done      <= 1'b0;
      q.rbBusy    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign link.serialDataOut  = q.dout;
  assign link.initStatus     = q.init;
  assign link.readbackData_b = q.rbData_b;
  assign link.devDoneOut     = 1'b0;
  assign link.devDoneOe      = q.doneOe;
  assign cfgDone             = q.done;
  assign readbackBusy        = q.rbBusy;
  assign cfgStore            = q.store;
endmodule // ssc_device

// ---- hdl/ssc_host.sv ----
/*
  Configuration source end: makes the configuration clock, sends bits,
  aborts, requests reprogram and runs readback.
  Assumes user requests are single-cycle pulses on clk.
*/
`timescale 1ns/1ns
module ssc_host (
  input  wire logic clk,
  input  wire logic rst_b,
  ssc_link_if.host  link,
  input  wire logic bitValid,
  input  wire logic bitData,
  output logic      bitReady,
  input  wire logic abortReq,
  input  wire logic progReq,
  input  wire logic rbReq,
  output logic      devReady,
  output logic      devDone,
  output logic      rbValid,
  output logic      rbBit
);
  typedef struct packed {
    ssc_pkg::ssc_host_state_t state;
    logic [6:0]               timer;
    logic [6:0]               rbCnt;
    logic                     config_clock;
    logic                     sdi;
    logic                     reset_b;
    logic                     doneOe;
    logic                     trig;
    logic                     donePrev;
    logic                     ready;
    logic                     done;
    logic                     bitRdy;
    logic                     rbVal;
    logic                     rbOut;
  } ssc_host_reg_t;

  localparam logic [6:0] HALF_LAST = 7'(ssc_pkg::CONFIG_CLOCK_HALF_CYC - 1);
  localparam logic [6:0] RB_LAST   = 7'(ssc_pkg::RB_HALF_CYC - 1);
  localparam logic [6:0] PROG_LAST = 7'(ssc_pkg::PROG_LOW_CYC - 1);
  localparam logic [6:0] RB_BITS   = 7'(ssc_pkg::CFG_STORE_BITS);

  ssc_host_reg_t q;
  ssc_host_reg_t d;
  logic [2:0]    pinS;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  ssc_sync #(.W(3), .RST_VAL(3'h1)) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .asyncIn  ({link.initStatus, link.doneProgramLine, link.readbackData_b}),
    .syncOut  (pinS)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d          = q;
    d.bitRdy   = 1'b0;
    d.rbVal    = 1'b0;
    d.ready    = pinS[2];
    d.done     = pinS[1];
    d.donePrev = pinS[1];
    d.timer    = q.timer + 7'h01;
    case (q.state)
      ssc_pkg::HST_IDLE: begin
        d.config_clock  = 1'b1;
        d.timer = 7'h00;
        if (abortReq) begin
          d.reset_b = 1'b0;
          d.state   = ssc_pkg::HST_ABORT;
        end else if (progReq) begin
          d.doneOe = 1'b1;
          d.state  = ssc_pkg::HST_PROG;
        end else if (rbReq && pinS[1] && q.donePrev) begin
          d.trig  = 1'b1;
          d.rbCnt = 7'h00;
          d.state = ssc_pkg::HST_RB_ARM;
        end else if (bitValid && pinS[2]) begin
          d.sdi    = bitData;
          d.bitRdy = 1'b1;
          d.config_clock   = 1'b0;
          d.state  = ssc_pkg::HST_SEND_LO;
        end
      end
      ssc_pkg::HST_ABORT: begin
        if (q.timer == PROG_LAST) begin
          d.reset_b = 1'b1;
          d.state   = ssc_pkg::HST_IDLE;
        end
      end
      ssc_pkg::HST_PROG: begin
        if (q.timer == PROG_LAST) begin
          d.doneOe = 1'b0;
          d.state  = ssc_pkg::HST_IDLE;
        end
      end
      ssc_pkg::HST_SEND_LO: begin
        if (q.timer == HALF_LAST) begin
          d.config_clock  = 1'b1;
          d.timer = 7'h00;
          d.state = ssc_pkg::HST_SEND_HI;
        end
      end
      ssc_pkg::HST_SEND_HI: begin
        if (q.timer == HALF_LAST) begin
          d.state = ssc_pkg::HST_IDLE;
        end
      end
      ssc_pkg::HST_RB_ARM: begin
        if (q.timer == RB_LAST) begin
          d.trig  = 1'b0;
          d.config_clock  = 1'b0;
          d.timer = 7'h00;
          d.state = ssc_pkg::HST_RB_LO;
        end
      end
      ssc_pkg::HST_RB_LO: begin
        if (q.timer == RB_LAST) begin
          d.config_clock  = 1'b1;
          d.timer = 7'h00;
          d.state = ssc_pkg::HST_RB_HI;
        end
      end
      ssc_pkg::HST_RB_HI: begin
        if (q.timer == RB_LAST) begin
          d.timer = 7'h00;
          if (q.rbCnt == RB_BITS) begin
            d.state = ssc_pkg::HST_IDLE;
          end else begin
            d.rbVal = 1'b1;
            d.rbOut = !pinS[0];
            d.rbCnt = q.rbCnt + 7'h01;
            d.config_clock  = 1'b0;
            d.state = ssc_pkg::HST_RB_LO;
          end
        end
      end
      default: begin
        d.state = ssc_pkg::HST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q.state    <= ssc_pkg::HST_IDLE;
      q.timer    <= 7'h00;
      q.rbCnt    <= 7'h00;
      q.config_clock     <= 1'b1;
      q.sdi      <= 1'b1;
      q.reset_b  <= 1'b1;
      q.doneOe   <= 1'b0;
      q.trig     <= 1'b0;
      q.donePrev <= 1'b0;
      q.ready    <= 1'b0;
      q.done     <= 1'b0;
      q.bitRdy   <= 1'b0;
      q.rbVal    <= 1'b0;
      q.rbOut    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign link.configClock  = q.config_clock;
  assign link.serialDataIn = q.sdi;
  assign link.cfgReset_b   = q.reset_b;
  assign link.modeSelect   = {ssc_pkg::MODE_SLAVE_SERIAL[2:1], ssc_pkg::MODE_SLAVE_SERIAL[0] & ~q.trig};
  assign link.hostDoneOut  = 1'b0;
  assign link.hostDoneOe   = q.doneOe;
  assign bitReady          = q.bitRdy;
  assign devReady          = q.ready;
  assign devDone           = q.done;
  assign rbValid           = q.rbVal;
  assign rbBit             = q.rbOut;
endmodule // ssc_host

// ---- dv/ssc_link_properties.sv ----
/*
  Concurrent checks on the link between configuration source and device.
  Assumes one clock and one reset shared by both ends.
*/
`timescale 1ns/1ns
module ssc_link_properties (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       configClock,
  input wire logic       serialDataOut,
  input wire logic       initStatus,
  input wire logic       cfgReset_b,
  input wire logic [2:0] modeSelect,
  input wire logic       readbackData_b,
  input wire logic       doneProgramLine
);
  // ==========================================================================
  // Helper counters
  // ==========================================================================
  logic [7:0] lowCnt_q;
  logic [7:0] rstLowCnt_q;
  logic [7:0] riseCnt_q;
  logic       clkSeen_q;
  logic [7:0] rbLeft_q;
  logic       trigSeen_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_q    <= 8'h00;
      rstLowCnt_q <= 8'h00;
      riseCnt_q   <= 8'h00;
      clkSeen_q   <= 1'h1;
      rbLeft_q    <= 8'h00;
      trigSeen_q  <= 1'h1;
    end else begin
      lowCnt_q    <= configClock ? 8'h00 : lowCnt_q + 8'h01;
      rstLowCnt_q <= cfgReset_b ? 8'h00 : rstLowCnt_q + 8'h01;
      riseCnt_q   <= !initStatus ? 8'h00 : riseCnt_q + {7'h00, configClock && !clkSeen_q};
      clkSeen_q   <= configClock;
      rbLeft_q    <= !doneProgramLine ? 8'h00 : (modeSelect[0] && !trigSeen_q) ? 8'h41
                   : rbLeft_q - {7'h00, rbLeft_q != 8'h00 && configClock && !clkSeen_q};
      trigSeen_q  <= modeSelect[0];
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_clk_low_max: assert property (lowCnt_q <= 8'h32)
    else $error("config clock low too long");
  a_clk_shape: assert property ($fell(configClock) && !doneProgramLine |-> (!configClock) [*4] ##1 configClock)
    else $error("config clock phase length wrong");
  a_rb_clk_slow: assert property ($fell(configClock) && doneProgramLine
    && (rbLeft_q != 8'h00 || $rose(modeSelect[0])) |-> (!configClock) [*6] ##1 configClock)
    else $error("readback clock phase length wrong");
  a_no_early_bits: assert property ($fell(configClock) |-> initStatus)
    else $error("clocking before init status high");
  a_idle_parked: assert property (!initStatus |-> configClock)
    else $error("config clock not parked high");
  a_dout_on_fall: assert property ($changed(serialDataOut) && initStatus |-> !configClock)
    else $error("serial output changed outside low phase");
  a_frame_len: assert property ($rose(doneProgramLine) |-> riseCnt_q >= 8'h48)
    else $error("done released before full frame");
  a_init_resp: assert property ($fell(doneProgramLine) |-> ##[0:70] !initStatus)
    else $error("init status slow after done line fall");
  a_filter_delay: assert property ($fell(initStatus) && !cfgReset_b |-> rstLowCnt_q >= 8'h1E)
    else $error("reset response not filtered");
  a_abort_taken: assert property (rstLowCnt_q == 8'h3C |-> !initStatus)
    else $error("long reset did not abort");
  a_rdata_idle: assert property (!doneProgramLine |-> readbackData_b)
    else $error("readback data active before done");
  a_mode_hold: assert property (!cfgReset_b |-> $stable(modeSelect))
    else $error("mode lines moved during reset");

  c_frame: cover property ($rose(doneProgramLine));
  c_reprog: cover property ($fell(doneProgramLine));
  c_abort: cover property (rstLowCnt_q == 8'h3C);
  c_readback: cover property ($rose(modeSelect[0]) && doneProgramLine);
endmodule // ssc_link_properties

// ---- dv/tb_top.sv ----
/*
  Testbench: host and device joined on one link, plus a second device
  driven directly by the bench for reset pulses and readback.
  Assumes a 10 MHz clock and active-low asynchronous reset.
*/
`timescale 1ns/1ns
module tb_top;
  localparam logic [63:0] PAT = 64'hA5C3_0F96_3C5A_E17B;
  localparam logic [7:0]  PRE = 8'hB2;
  logic        clk, rst_b, bitValid, bitData, abortReq, progReq, rbReq;
  logic        bitReady, devReady, devDone, cfgDoneA, cfgDoneB, busyB, rbValid, rbBit;
  logic [63:0] storeA, storeB;
  int          n_mismatch, total_checks;
  ssc_link_if  linkA ();
  ssc_link_if  linkB ();

  // ==========================================================================
  // Instances
  // ==========================================================================
  ssc_host i_ssc_host (.clk(clk), .rst_b(rst_b), .link(linkA.host), .bitValid(bitValid), .bitData(bitData),
    .bitReady(bitReady), .abortReq(abortReq), .progReq(progReq), .rbReq(rbReq), .devReady(devReady),
    .devDone(devDone), .rbValid(rbValid), .rbBit(rbBit));
  ssc_device i_ssc_device (.clk(clk), .rst_b(rst_b), .link(linkA.device), .cfgDone(cfgDoneA),
    .readbackBusy(), .cfgStore(storeA));
  ssc_device i_ssc_device_rb (.clk(clk), .rst_b(rst_b), .link(linkB.device), .cfgDone(cfgDoneB),
    .readbackBusy(busyB), .cfgStore(storeB));
  ssc_link_properties i_ssc_link_properties (.clk(clk), .rst_b(rst_b), .configClock(linkA.configClock),
    .serialDataOut(linkA.serialDataOut), .initStatus(linkA.initStatus), .cfgReset_b(linkA.cfgReset_b),
    .modeSelect(linkA.modeSelect), .readbackData_b(linkA.readbackData_b),
    .doneProgramLine(linkA.doneProgramLine));

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string w, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk1(input string w, input logic e, input logic g);
    check(w, {63'h0, e}, {63'h0, g});
  endtask

  task automatic waitSig(input int sel, input logic val, input int lim);
    logic s;
    for (int i = 0; i <= lim; i++) begin
      s = sel == 0 ? devReady : sel == 1 ? devDone : sel == 2 ? linkB.initStatus : rbValid;
      if (s === val) return;
      @(posedge clk);
    end
    n_mismatch++;
    $display("mismatch wait %0d expected %b seen %b", sel, val, s);
    final_report();
  endtask

  task automatic sendA(input logic b);
    @(posedge clk);
    bitValid <= 1'h1;
    bitData  <= b;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk);
      if (bitReady === 1'h1) begin
        bitValid <= 1'h0;
        return;
      end
    end
    n_mismatch++;
    $display("mismatch bitReady expected 1 seen %b", bitReady);
    final_report();
  endtask

  task automatic frameA(input logic [63:0] p);
    logic [71:0] f;
    f = {PRE, p};
    for (int i = 71; i >= 0; i--) sendA(f[i]);
  endtask

  // Bench clock: low phase then high phase, parked high after
  task automatic bitB(input logic b, input int h, output logic so, output logic rd);
    linkB.configClock  <= 1'h0;
    linkB.serialDataIn <= b;
    repeat (h) @(posedge clk);
    so = linkB.serialDataOut;
    linkB.configClock <= 1'h1;
    repeat (h) @(posedge clk);
    rd = linkB.readbackData_b;
  endtask

  task automatic frameB(input logic [63:0] p);
    logic [73:0] f;
    logic        so;
    logic        rd;
    f = {PRE, p, 2'h1};
    for (int i = 73; i >= 0; i--) begin
      bitB(f[i], 4, so, rd);
      if ((i >= 65 && i <= 72) || i == 0) chk1("forwarded bit", f[i+1], so);
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic so;
    logic rd;
    {bitValid, bitData, abortReq, progReq, rbReq} = 5'h00;
    n_mismatch = 0;
    total_checks = 0;
    rst_b = 1'h0;
    linkB.configClock = 1'h1;
    linkB.serialDataIn = 1'h1;
    linkB.cfgReset_b = 1'h1;
    linkB.modeSelect = 3'h7;
    linkB.hostDoneOut = 1'h0;
    linkB.hostDoneOe = 1'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    waitSig(0, 1'h1, 200);
    for (int i = 0; i < 5; i++) sendA(PRE[i]);
    repeat (10) @(posedge clk);
    abortReq <= 1'h1;
    @(posedge clk);
    abortReq <= 1'h0;
    waitSig(0, 1'h0, 80);
    waitSig(0, 1'h1, 200);
    frameA(~PAT);
    waitSig(1, 1'h1, 40);
    check("stored frame", ~PAT, storeA);
    repeat (10) @(posedge clk);
    progReq <= 1'h1;
    @(posedge clk);
    progReq <= 1'h0;
    waitSig(0, 1'h0, 70);
    chk1("done after reprogram", 1'h0, cfgDoneA);
    waitSig(0, 1'h1, 200);
    frameA(PAT);
    waitSig(1, 1'h1, 40);
    check("reloaded frame", PAT, storeA);
    // Host-driven readback on the first link
    rbReq <= 1'h1;
    @(posedge clk);
    rbReq <= 1'h0;
    for (int i = 63; i >= 0; i--) begin
      waitSig(3, 1'h1, 30);
      chk1("host readback bit", PAT[i], rbBit);
      @(posedge clk);
    end
    check("store after host readback", PAT, storeA);
    // Bench-driven link: short and long reset pulses in mid-load
    for (int i = 0; i < 5; i++) bitB(PRE[7-i], 4, so, rd);
    linkB.cfgReset_b <= 1'h0;
    repeat (10) @(posedge clk);
    linkB.cfgReset_b <= 1'h1;
    repeat (40) @(posedge clk);
    chk1("init after short reset", 1'h1, linkB.initStatus);
    linkB.cfgReset_b <= 1'h0;
    repeat (60) @(posedge clk);
    chk1("init after abort", 1'h0, linkB.initStatus);
    linkB.cfgReset_b <= 1'h1;
    waitSig(2, 1'h1, 200);
    frameB(PAT);
    chk1("device b done", 1'h1, cfgDoneB);
    check("device b store", PAT, storeB);
    // Readback after completion, trigger on mode bit 0 rising
    linkB.modeSelect <= 3'h6;
    repeat (5) @(posedge clk);
    linkB.modeSelect <= 3'h7;
    repeat (5) @(posedge clk);
    for (int i = 63; i >= 0; i--) begin
      bitB(1'h1, 5, so, rd);
      chk1("readback bit", !PAT[i], rd);
    end
    chk1("readback busy", 1'h1, busyB);
    bitB(1'h1, 5, so, rd);
    chk1("readback ended", 1'h0, busyB);
    check("store after readback", PAT, storeB);
    final_report();
  end
endmodule // tb_top
